// ==== rtl/keypad_level_pkg.sv ====
// Constants and carrier types for the keypad level interrupt block.
// Assumes a core clock domain and an 8-bit special function register port.
`default_nettype none

package keypad_level_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] LINE_LEVEL_SELECT_OFFSET = 8'h9C;
  localparam logic [7:0] LINE_IRQ_ENABLE_OFFSET   = 8'h9D;
  localparam logic [7:0] LINE_DETECT_FLAGS_OFFSET = 8'h9E;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0] LINE_LEVEL_SELECT_RESET  = 8'h00;
  localparam logic [7:0] LINE_IRQ_ENABLE_RESET    = 8'h00;
  localparam logic [7:0] LINE_DETECT_FLAGS_RESET  = 8'h00;
  localparam logic [7:0] PIN_SYNC_RESET           = 8'hFF;
  localparam logic [7:0] READ_DATA_RESET          = 8'h00;
  localparam logic [7:0] UNMAPPED_READ_VALUE      = 8'h00;

  // ****************************************************************
  // Carrier types
  // ****************************************************************
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } sfr_req_t;

  typedef enum logic [1:0] {
    SEL_NONE  = 2'b00,
    SEL_LEVEL = 2'b01,
    SEL_EN    = 2'b10,
    SEL_FLAGS = 2'b11
  } reg_sel_t;

endpackage : keypad_level_pkg

`default_nettype wire

// ==== rtl/keypad_level_interrupt.sv ====
// Keypad level interrupt front end for the eight port-one pins.
// Assumes pins synchronous-safe via two flops, core clock running,
// and the core's global keyboard enable bit supplied as a level.
`default_nettype none

module keypad_level_interrupt #(
  parameter int LINES = 8
) (
  input  wire logic                       CLK_I,
  input  wire logic                       RESET_I,
  input  wire logic [LINES-1:0]           PORT_ONE_PINS_I,
  input  wire keypad_level_pkg::sfr_req_t SFR_REQ_I,
  input  wire logic                       KEYPAD_GLOBAL_IRQ_ENABLE_I,
  output logic [7:0]                      SFR_RDATA_O,
  output logic                            SFR_HIT_O,
  output logic                            KEYPAD_IRQ_O,
  output logic                            WAKE_O,
  output logic [LINES-1:0]                LINE_KEY_MODE_O
);

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  function automatic keypad_level_pkg::reg_sel_t decode(
    input logic [7:0] addr
  );
    if (addr == keypad_level_pkg::LINE_LEVEL_SELECT_OFFSET) begin
      decode = keypad_level_pkg::SEL_LEVEL;
    end else if (addr == keypad_level_pkg::LINE_IRQ_ENABLE_OFFSET) begin
      decode = keypad_level_pkg::SEL_EN;
    end else if (addr == keypad_level_pkg::LINE_DETECT_FLAGS_OFFSET) begin
      decode = keypad_level_pkg::SEL_FLAGS;
    end else begin
      decode = keypad_level_pkg::SEL_NONE;
    end
  endfunction : decode

  // Bit set where the pin matches its programmed level
  function automatic logic [LINES-1:0] level_hit(
    input logic [LINES-1:0] pins,
    input logic [LINES-1:0] lvl
  );
    level_hit = ~(pins ^ lvl);
  endfunction : level_hit

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic [LINES-1:0]          pin_meta_q;
  logic [LINES-1:0]          pin_sync_q;
  logic [LINES-1:0]          level_q;
  logic [LINES-1:0]          en_q;
  logic [LINES-1:0]          flag_q;
  logic [LINES-1:0]          flag_d;
  logic [LINES-1:0]          detect;
  logic [7:0]                rdata_d;
  keypad_level_pkg::reg_sel_t sel;
  logic                      wr_level;
  logic                      wr_en;
  logic                      wr_flags;

  // ****************************************************************
  // Register decode
  // ****************************************************************
  assign sel      = decode(SFR_REQ_I.addr);
  assign wr_level = SFR_REQ_I.wr && (sel == keypad_level_pkg::SEL_LEVEL);
  assign wr_en    = SFR_REQ_I.wr && (sel == keypad_level_pkg::SEL_EN);
  assign wr_flags = SFR_REQ_I.wr && (sel == keypad_level_pkg::SEL_FLAGS);

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      pin_meta_q <= LINES'(keypad_level_pkg::PIN_SYNC_RESET);
      pin_sync_q <= LINES'(keypad_level_pkg::PIN_SYNC_RESET);
    end else begin
      pin_meta_q <= PORT_ONE_PINS_I;
      pin_sync_q <= pin_meta_q;
    end
  end

  assign detect = level_hit(pin_sync_q, level_q);

  // ****************************************************************
  // Level select register
  // ****************************************************************
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      level_q <=
        LINES'(keypad_level_pkg::LINE_LEVEL_SELECT_RESET);
    end else if (wr_level) begin
      level_q <= SFR_REQ_I.wdata[LINES-1:0];
    end
  end

  // ****************************************************************
  // Line enable register
  // ****************************************************************
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      en_q <= LINES'(keypad_level_pkg::LINE_IRQ_ENABLE_RESET);
    end else if (wr_en) begin
      en_q <= SFR_REQ_I.wdata[LINES-1:0];
    end
  end

  // ****************************************************************
  // Detect flags: set wins over a software clear
  // ****************************************************************
  always_comb begin
    flag_d = flag_q;
    if (wr_flags) begin
      flag_d = SFR_REQ_I.wdata[LINES-1:0];
    end
    flag_d = flag_d | detect;
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      flag_q <=
        LINES'(keypad_level_pkg::LINE_DETECT_FLAGS_RESET);
    end else begin
      flag_q <= flag_d;
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************
  always_comb begin
    rdata_d = keypad_level_pkg::UNMAPPED_READ_VALUE;
    case (sel)
      keypad_level_pkg::SEL_LEVEL: rdata_d = 8'(level_q);
      keypad_level_pkg::SEL_EN:    rdata_d = 8'(en_q);
      keypad_level_pkg::SEL_FLAGS: rdata_d = 8'(flag_q);
      default:                     rdata_d =
                                     keypad_level_pkg::UNMAPPED_READ_VALUE;
    endcase
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      SFR_RDATA_O <= keypad_level_pkg::READ_DATA_RESET;
      SFR_HIT_O   <= 1'b0;
    end else if (SFR_REQ_I.rd) begin
      SFR_RDATA_O <= rdata_d;
      SFR_HIT_O   <= (sel != keypad_level_pkg::SEL_NONE);
    end else begin
      SFR_HIT_O   <= 1'b0;
    end
  end

  // ****************************************************************
  // Combined request, wake and pin mode
  // ****************************************************************
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      KEYPAD_IRQ_O    <= 1'b0;
      WAKE_O          <= 1'b0;
      LINE_KEY_MODE_O <= '0;
    end else begin
      // One request for all lines, masked per line and globally
      KEYPAD_IRQ_O    <= KEYPAD_GLOBAL_IRQ_ENABLE_I
                         && (|(flag_q & en_q));
      WAKE_O          <= |((detect | flag_q) & en_q);
      LINE_KEY_MODE_O <= en_q;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  sequence seq_lines_off;
    (en_q == '0) [*2];
  endsequence

  sequence seq_clear_during_level;
    wr_flags && (detect != '0);
  endsequence

  sequence seq_pin_reaches_sync;
    ##2 (pin_sync_q == $past(PORT_ONE_PINS_I, 2));
  endsequence

  sequence seq_mode_follows;
    ##2 (LINE_KEY_MODE_O == LINES'($past(SFR_REQ_I.wdata, 2)));
  endsequence

  chk_flag_sets: assert property (
    (detect != '0) |=> ((flag_q & $past(detect)) == $past(detect)))
    else $error("Flag not set by matching level");

  chk_flag_sticky: assert property (
    !wr_flags |=> ((flag_q & $past(flag_q)) == $past(flag_q)))
    else $error("Flag dropped without software clear");

  chk_global_gate: assert property (
    !KEYPAD_GLOBAL_IRQ_ENABLE_I |=> !KEYPAD_IRQ_O)
    else $error("Request raised while globally disabled");

  chk_disabled_quiet: assert property (
    seq_lines_off |-> !KEYPAD_IRQ_O && (LINE_KEY_MODE_O == '0))
    else $error("Disabled lines produced a request");

  chk_irq_raise: assert property (
    (KEYPAD_GLOBAL_IRQ_ENABLE_I && ((flag_q & en_q) != '0))
    |=> KEYPAD_IRQ_O)
    else $error("Enabled flag gave no request");

  chk_level_sense: assert property (
    ((level_q == '0 && pin_sync_q == '0)
     || (level_q == '1 && pin_sync_q == '1)) |=> (flag_q == '1))
    else $error("Level selection not honoured");

  chk_wake_path: assert property (
    ((detect & en_q) != '0) |=> WAKE_O)
    else $error("Enabled detection did not wake");

  chk_reset_zero: assert property (
    @(posedge CLK_I) disable iff (1'b0)
    RESET_I |-> (level_q == '0 && en_q == '0 && flag_q == '0))
    else $error("Registers not zero in reset");

  chk_reflag: assert property (
    seq_clear_during_level
    |=> ((flag_q & $past(detect)) == $past(detect)))
    else $error("Cleared flag not re-set under level");

  chk_read_level: assert property (
    (SFR_REQ_I.rd && sel == keypad_level_pkg::SEL_LEVEL)
    |=> SFR_HIT_O && (SFR_RDATA_O == 8'($past(level_q))))
    else $error("Level register read back wrong");

  chk_irq_drop: assert property (
    !(KEYPAD_GLOBAL_IRQ_ENABLE_I && ((flag_q & en_q) != '0))
    |=> !KEYPAD_IRQ_O)
    else $error("Request without an enabled flag");

  chk_line_mask: assert property (
    ((flag_q & en_q) == '0)
    |=> !KEYPAD_IRQ_O)
    else $error("Masked flag gave a request");

  chk_wake_quiet: assert property (
    (((detect | flag_q) & en_q) == '0)
    |=> !WAKE_O)
    else $error("Wake raised with no enabled line");

  chk_wake_no_global: assert property (
    (!KEYPAD_GLOBAL_IRQ_ENABLE_I && ((detect & en_q) != '0))
    |=> WAKE_O)
    else $error("Wake blocked by global enable");

  chk_flag_write: assert property (
    wr_flags
    |=> (flag_q == ($past(SFR_REQ_I.wdata[LINES-1:0]) | $past(detect))))
    else $error("Flag write did not merge with level");

  chk_flag_clear: assert property (
    (wr_flags && (SFR_REQ_I.wdata == '0) && (detect == '0))
    |=> (flag_q == '0))
    else $error("Software clear did not clear flags");

  chk_flag_hold: assert property (
    (!wr_flags && (detect == '0))
    |=> $stable(flag_q))
    else $error("Flags changed with no level or write");

  chk_sync_depth: assert property (
    1'b1
    |-> seq_pin_reaches_sync)
    else $error("Pin not seen two cycles later");

  // ****************************************************************
  // Register port checks
  // ****************************************************************
  chk_level_write: assert property (
    wr_level
    |=> (level_q == $past(SFR_REQ_I.wdata[LINES-1:0])))
    else $error("Level register write lost");

  chk_enable_write: assert property (
    wr_en
    |=> (en_q == $past(SFR_REQ_I.wdata[LINES-1:0])))
    else $error("Enable register write lost");

  chk_mode_copy: assert property (
    wr_en
    |-> seq_mode_follows)
    else $error("Pin mode did not follow enable");

  chk_read_flags: assert property (
    (SFR_REQ_I.rd && sel == keypad_level_pkg::SEL_FLAGS)
    |=> SFR_HIT_O && (SFR_RDATA_O == 8'($past(flag_q))))
    else $error("Flag register read back wrong");

  chk_read_enable: assert property (
    (SFR_REQ_I.rd && sel == keypad_level_pkg::SEL_EN)
    |=> SFR_HIT_O && (SFR_RDATA_O == 8'($past(en_q))))
    else $error("Enable register read back wrong");

endmodule : keypad_level_interrupt

`default_nettype wire

// ==== sim/keypad_model.sv ====
// Keypad switch model driving the port-one sense pins.
// Assumes pull-ups: a released key leaves its line high.
`default_nettype none

module keypad_model (
  input  wire logic [7:0] press_i,
  output logic      [7:0] pins_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pressed key pulls its line low, released line floats up
  assign pins_o = ~press_i;

endmodule : keypad_model

`default_nettype wire

// ==== sim/keypad_level_interrupt_test.sv ====
// Self-checking bench for the keypad level interrupt block.
// Assumes the keypad model on the pins and software acting by tasks.
`default_nettype none

`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin \
  n_errors++; $display("BAD %s exp %h got %h", nm, e, g); end end

module keypad_level_interrupt_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic                       clk   = 1'b1;
  logic                       rst   = 1'b0;
  logic                       glob  = 1'b0;
  logic [7:0]                 press = 8'h00;
  logic [7:0]                 pins;
  logic [7:0]                 rdata;
  logic [7:0]                 mode;
  logic                       hit;
  logic                       irq;
  logic                       wake;
  keypad_level_pkg::sfr_req_t req   = '0;
  int                         n_errors  = 0;
  int                         tests_run = 0;
  int                         cycles    = 0;

  always #12.5 clk = ~clk;

  keypad_model kp (.press_i(press), .pins_o(pins));

  keypad_level_interrupt dut (
    .CLK_I(clk), .RESET_I(rst), .PORT_ONE_PINS_I(pins), .SFR_REQ_I(req),
    .KEYPAD_GLOBAL_IRQ_ENABLE_I(glob), .SFR_RDATA_O(rdata),
    .SFR_HIT_O(hit), .KEYPAD_IRQ_O(irq), .WAKE_O(wake),
    .LINE_KEY_MODE_O(mode));

  // ****************************************************************
  // Register access and waits
  // ****************************************************************
  task automatic idle(input int n);
    repeat (n) @(negedge clk);
  endtask : idle

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    @(negedge clk);
    req = '0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e,
                    input logic h);
    @(negedge clk);
    req = '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    @(negedge clk);
    req = '0;
    `CHK("rdata", e, rdata)
    `CHK("hit", h, hit)
  endtask : rd

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    rd(8'h9C, 8'h00, 1'b1);
    rd(8'h9D, 8'h00, 1'b1);
    rd(8'h9E, 8'h00, 1'b1);
    `CHK("mode", 8'h00, mode)
  endtask : t_reset

  task automatic t_regs;
    wr(8'h9C, 8'hA5);
    rd(8'h9C, 8'hA5, 1'b1);
    idle(3);
    rd(8'h9E, 8'hA5, 1'b1);
    wr(8'h9C, 8'h00);
    idle(3);
    wr(8'h9E, 8'h00);
    rd(8'h9E, 8'h00, 1'b1);
    wr(8'h9D, 8'h3C);
    rd(8'h9D, 8'h3C, 1'b1);
    `CHK("mode", 8'h3C, mode)
    rd(8'h9F, 8'h00, 1'b0);
    wr(8'h9D, 8'h00);
  endtask : t_regs

  task automatic t_lines;
    for (int i = 0; i < 8; i++) begin
      press = 8'h01 << i;
      idle(4);
      rd(8'h9E, 8'h01 << i, 1'b1);
      press = 8'h00;
      idle(3);
      wr(8'h9E, 8'h00);
    end
    press = 8'hFF;
    idle(4);
    rd(8'h9E, 8'hFF, 1'b1);
    press = 8'h00;
    idle(3);
    wr(8'h9E, 8'h00);
    wr(8'h9C, 8'hFF);
    idle(3);
    rd(8'h9E, 8'hFF, 1'b1);
    wr(8'h9C, 8'h00);
    wr(8'h9E, 8'h00);
    rd(8'h9E, 8'h00, 1'b1);
  endtask : t_lines

  task automatic t_irq;
    glob  = 1'b1;
    press = 8'h04;
    idle(5);
    `CHK("irq off", 1'b0, irq)
    wr(8'h9D, 8'h04);
    idle(3);
    `CHK("irq on", 1'b1, irq)
    `CHK("wake on", 1'b1, wake)
    glob = 1'b0;
    idle(3);
    `CHK("irq gated", 1'b0, irq)
    glob = 1'b1;
    wr(8'h9E, 8'h00);
    idle(2);
    rd(8'h9E, 8'h04, 1'b1);
    press = 8'h00;
    idle(4);
    rd(8'h9E, 8'h04, 1'b1);
    wr(8'h9E, 8'h00);
    idle(3);
    `CHK("irq clear", 1'b0, irq)
    `CHK("wake clear", 1'b0, wake)
  endtask : t_irq

  task automatic t_rerst;
    wr(8'h9C, 8'h5E);
    idle(3);
    `CHK("irq pre", 1'b1, irq)
    rst = 1'b1;
    idle(2);
    `CHK("irq rst", 1'b0, irq)
    `CHK("wake rst", 1'b0, wake)
    rst = 1'b0;
    rd(8'h9C, 8'h00, 1'b1);
    rd(8'h9D, 8'h00, 1'b1);
    rd(8'h9E, 8'h00, 1'b1);
    `CHK("mode rst", 8'h00, mode)
  endtask : t_rerst

  // ****************************************************************
  // Verdict and hang guard
  // ****************************************************************
  task automatic give_verdict;
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      give_verdict();
    end
  end

  initial begin
    @(negedge clk);
    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_regs();
    t_lines();
    t_irq();
    t_rerst();
    give_verdict();
  end

endmodule : keypad_level_interrupt_test

`default_nettype wire
